// *** src/pps_pkg.sv ***
// Constants and types shared by the parallel port slave block
// Assumes: compiled before every other design file
package pps_pkg;
    // Register offsets
    localparam logic [11:0] PPS_A_OSTAT  = 12'hF54;
    localparam logic [11:0] PPS_A_ISTAT  = 12'hF55;
    localparam logic [11:0] PPS_A_PENL   = 12'hF56;
    localparam logic [11:0] PPS_A_PENH   = 12'hF57;
    localparam logic [11:0] PPS_A_CTRL   = 12'hF5E;
    localparam logic [11:0] PPS_A_DIN1L  = 12'hF60;
    localparam logic [11:0] PPS_A_DIN1H  = 12'hF61;
    localparam logic [11:0] PPS_A_DIN2L  = 12'hF62;
    localparam logic [11:0] PPS_A_DIN2H  = 12'hF63;
    localparam logic [11:0] PPS_A_DOUT2L = 12'hF64;
    localparam logic [11:0] PPS_A_DOUT2H = 12'hF65;
    localparam logic [11:0] PPS_A_ADRL   = 12'hF6E;
    localparam logic [11:0] PPS_A_ADRH   = 12'hF6F;
    // Field positions and masks
    localparam int          PPS_B_STICKY = 6;
    localparam int          PPS_B_CSBIT  = 6;
    localparam logic [7:0]  PPS_CTRL_MSK = 8'hDB;
    // Reset values
    localparam logic [3:0]  PPS_RST_EMPTY = 4'hF;
    localparam logic [3:0]  PPS_RST_FULL  = 4'h0;
    localparam logic [7:0]  PPS_RST_BYTE  = 8'h00;
    // Field codes
    localparam logic [1:0]  PPS_CSF_CS   = 2'b10;
    localparam logic [1:0]  PPS_INCM_BUF = 2'b11;
    // Buffering
    localparam int          PPS_FIFO_DEPTH = 8;
    localparam int          PPS_SYNC_W     = 13;

    typedef enum logic [1:0] {
        PPS_LEGACY    = 2'b00,
        PPS_ADDRESSED = 2'b01,
        PPS_MASTER2   = 2'b10,
        PPS_MASTER1   = 2'b11
    } pps_mode_e;

    typedef struct packed {
        logic [1:0] cs_function_select;
        logic       rsv_a;
        logic [1:0] incm;
        logic       rsv_b;
        pps_mode_e  mode;
    } pps_ctrl_s;

    typedef struct packed {
        logic       cs;
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] data;
    } pps_pin_in_s;

    typedef struct packed {
        logic [1:0] slot;
        logic [7:0] data;
    } pps_wr_s;
endpackage

// *** src/pps_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module pps_sync
    import pps_pkg::*;
#(
    parameter int W = PPS_SYNC_W
)
(
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // pps_sync

// *** src/pps_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ps
module pps_fifo
    import pps_pkg::*;
#(
    parameter int W     = 10,
    parameter int DEPTH = PPS_FIFO_DEPTH
)
(
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output      logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output      logic         out_valid,
    input  wire logic         out_ready,
    output      logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + AW'(1);
            if (pop)
                rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // pps_fifo

// *** src/pps_core.sv ***
// Parallel port slave buffers, status flags, pin enables, address regs
// Assumes: external pins async to clk_sys; plain register port on clk_sys
// How it works
// RL1: CS pin enable set drives chip-select pin; clear leaves it port I/O.
// RL2: Each address pin enable 7..2 hands its pin to the port.
// RL3: Low two enables hand address/latch-strobe pins to the port.
// RL4: Input-all-full reads 1 only when every writable input byte is full.
// RL5: Write into a full input byte sets sticky overflow.
// RL6: Slot-full bit set by incoming byte, cleared by software read.
// RL7: Output-all-empty is 1 when every readable output byte empty; resets 1.
// RL8: External read of empty output byte sets sticky underflow.
// RL9: Slot-empty bits reset 1, cleared by software write, set when read.
// RL10: First input pair takes slave input, master in/out data.
// RL11: Second input pair used only in buffered or addressed slave modes.
// RL12: Master address and first output pair share one storage.
// RL13: Second output pair only serves buffered or addressed slave modes.
// RL14: CS function 10 makes bit 6 chip select, else address bit 14.
// RL15: Address high bits 5..0 give address 13..8; bit 7 reads zero.
// RL16: Buffered mode pointer walks input buffers 0 to 3 per write.
// RL17: External master writes with chip select and write strobe both high.
// RL18: Writing 0 clears overflow/underflow; writing 1 does nothing.
`timescale 1ns/1ps
module pps_core
    import pps_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [7:0]  reg_rdata_q,
    input  pps_pin_in_s      pin_i,
    output      logic [7:0]  data_out_q,
    output      logic        data_oe_q,
    output      logic        cs_line_q,
    output      logic        cs_line_oe_q,
    output      logic [7:0]  port_addr_q,
    output      logic [7:0]  port_addr_oe_q,
    output      logic [14:0] master_addr_q
);
    pps_pin_in_s pin_s;
    pps_ctrl_s   ctrl_q;
    pps_wr_s     push_d;
    pps_wr_s     pop_d;
    logic [7:0]  in_buf_q [4];
    logic [7:0]  out_buf_q [4];
    logic [3:0]  full_q;
    logic [3:0]  empty_q;
    logic        ov_q;
    logic        uf_q;
    logic [7:0]  pen_low_q;
    logic        cs_pen_q;
    logic [1:0]  in_ptr_q;
    logic [1:0]  out_ptr_q;
    logic        wr_act_q;
    logic        rd_act_q;
    logic [7:0]  wr_byte_q;
    logic [1:0]  wr_addr_q;
    logic [7:0]  rd_mux;
    logic        is_master;
    logic        buffered;
    logic        addressed;
    logic        wr_act;
    logic        rd_act;
    logic        wr_end;
    logic        rd_start;
    logic        fifo_rdy;
    logic        pop_v;
    logic        pop_rdy;
    logic        pop_fire;
    logic        ov_set;
    logic        uf_set;
    logic [1:0]  rslot;
    logic [2:0]  din_a;
    logic [2:0]  dout_a;
    logic        sw_din_rd;
    logic        sw_dout_wr;
    logic        all_full;
    logic        all_empty;
    logic [3:0]  full_set;
    logic [3:0]  full_clr;
    logic [3:0]  empty_set;
    logic [3:0]  empty_clr;

    // Input buffer decode: {hit, index}
    function automatic logic [2:0] din_dec(input logic [11:0] a);
        din_dec = 3'h0;
        if (a == PPS_A_DIN1L)
            din_dec = 3'h4;
        else if (a == PPS_A_DIN1H)
            din_dec = 3'h5;
        else if (a == PPS_A_DIN2L)
            din_dec = 3'h6;
        else if (a == PPS_A_DIN2H)
            din_dec = 3'h7;
    endfunction

    // Output buffer decode: {hit, index}
    function automatic logic [2:0] dout_dec(input logic [11:0] a);
        dout_dec = 3'h0;
        if (a == PPS_A_ADRL)
            dout_dec = 3'h4;
        else if (a == PPS_A_ADRH)
            dout_dec = 3'h5;
        else if (a == PPS_A_DOUT2L)
            dout_dec = 3'h6;
        else if (a == PPS_A_DOUT2H)
            dout_dec = 3'h7;
    endfunction

    pps_sync #(.W(PPS_SYNC_W)) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .d       (pin_i),
        .q       (pin_s)
    );

    // Mode decode
    assign is_master = ctrl_q.mode[1];
    assign addressed = (ctrl_q.mode == PPS_ADDRESSED);
    assign buffered  = (ctrl_q.mode == PPS_LEGACY) && (ctrl_q.incm == PPS_INCM_BUF);
    assign wr_act    = pin_s.cs & pin_s.wr; // [RL17]
    assign rd_act    = pin_s.cs & pin_s.rd;
    assign wr_end    = wr_act_q & ~wr_act & ~is_master;
    assign rd_start  = rd_act & ~rd_act_q & ~is_master;
    assign din_a     = din_dec(reg_addr);
    assign dout_a    = dout_dec(reg_addr);
    assign sw_din_rd = reg_rd & din_a[2];
    assign sw_dout_wr = reg_wr & dout_a[2];

    // Strobe tracking, byte captured while strobe is active, held after release
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_act_q  <= 1'b0;
            rd_act_q  <= 1'b0;
            wr_byte_q <= PPS_RST_BYTE;
            wr_addr_q <= 2'h0;
        end
        else
        begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (wr_act)
            begin
                wr_byte_q <= pin_s.data;
                wr_addr_q <= pin_s.addr;
            end
        end
    end

    // Slot choice for an incoming byte
    always_comb
    begin
        push_d.data = wr_byte_q;
        if (addressed)
            push_d.slot = wr_addr_q; // [RL11]
        else if (buffered)
            push_d.slot = in_ptr_q; // [RL16]
        else
            push_d.slot = 2'h0; // [RL10]
    end

    // Byte queue; drain stalls while software reads an input byte
    assign pop_rdy  = ~sw_din_rd;
    assign pop_fire = pop_v & pop_rdy;

    pps_fifo #(.W($bits(pps_wr_s)), .DEPTH(PPS_FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (wr_end),
        .in_ready  (fifo_rdy),
        .in_data   (push_d),
        .out_valid (pop_v),
        .out_ready (pop_rdy),
        .out_data  (pop_d)
    );

    // Input side flags
    assign ov_set   = (wr_end & ~fifo_rdy) | (pop_fire & full_q[pop_d.slot]); // [RL5]
    assign full_set = (pop_fire & ~full_q[pop_d.slot]) ? (4'h1 << pop_d.slot) : 4'h0;
    assign full_clr = sw_din_rd ? (4'h1 << din_a[1:0]) : 4'h0;
    assign all_full = (buffered | addressed) ? &full_q : full_q[0]; // [RL4]

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            full_q <= PPS_RST_FULL;
        else
            full_q <= (full_q & ~full_clr) | full_set; // [RL6]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            ov_q <= 1'b0;
        else if (ov_set)
            ov_q <= 1'b1; // [RL5]
        else if (reg_wr && reg_addr == PPS_A_ISTAT && !reg_wdata[PPS_B_STICKY])
            ov_q <= 1'b0; // [RL18]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            in_ptr_q <= 2'h0;
        else if (wr_end && buffered)
            in_ptr_q <= in_ptr_q + 2'h1; // [RL16]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                in_buf_q[i] <= PPS_RST_BYTE;
        end
        else if (pop_fire && !full_q[pop_d.slot])
            in_buf_q[pop_d.slot] <= pop_d.data;
        else if (reg_wr && din_a[2] && is_master)
            in_buf_q[din_a[1:0]] <= reg_wdata; // [RL10]
    end

    // Output side
    always_comb
    begin
        if (addressed)
            rslot = pin_s.addr;
        else if (buffered)
            rslot = out_ptr_q; // [RL13]
        else
            rslot = 2'h0;
    end

    assign uf_set    = rd_start & empty_q[rslot]; // [RL8]
    assign empty_set = (rd_start & ~empty_q[rslot]) ? (4'h1 << rslot) : 4'h0;
    assign empty_clr = (sw_dout_wr & ~is_master) ? (4'h1 << dout_a[1:0]) : 4'h0;
    assign all_empty = (buffered | addressed) ? &empty_q : empty_q[0]; // [RL7]

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            empty_q <= PPS_RST_EMPTY;
        else
            empty_q <= (empty_q & ~empty_clr) | empty_set; // [RL9]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            uf_q <= 1'b0;
        else if (uf_set)
            uf_q <= 1'b1; // [RL8]
        else if (reg_wr && reg_addr == PPS_A_OSTAT && !reg_wdata[PPS_B_STICKY])
            uf_q <= 1'b0; // [RL18]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            out_ptr_q <= 2'h0;
        else if (rd_start && buffered)
            out_ptr_q <= out_ptr_q + 2'h1;
    end

    // One storage for master address and first output pair
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                out_buf_q[i] <= PPS_RST_BYTE;
        end
        else if (sw_dout_wr)
            out_buf_q[dout_a[1:0]] <= reg_wdata; // [RL12]
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            data_out_q <= PPS_RST_BYTE;
            data_oe_q  <= 1'b0;
        end
        else
        begin
            if (rd_start && !empty_q[rslot])
                data_out_q <= out_buf_q[rslot];
            data_oe_q <= rd_act & ~is_master;
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q    <= pps_ctrl_s'(PPS_RST_BYTE);
            pen_low_q <= PPS_RST_BYTE;
            cs_pen_q  <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == PPS_A_CTRL)
                ctrl_q <= pps_ctrl_s'(reg_wdata & PPS_CTRL_MSK);
            else if (reg_addr == PPS_A_PENL)
                pen_low_q <= reg_wdata;
            else if (reg_addr == PPS_A_PENH)
                cs_pen_q <= reg_wdata[PPS_B_CSBIT];
        end
    end

    // Pin ownership and master address
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cs_line_q      <= 1'b0;
            cs_line_oe_q   <= 1'b0;
            port_addr_q    <= PPS_RST_BYTE;
            port_addr_oe_q <= PPS_RST_BYTE;
            master_addr_q  <= 15'h0000;
        end
        else
        begin
            cs_line_oe_q <= cs_pen_q & is_master; // [RL1]
            if (ctrl_q.cs_function_select == PPS_CSF_CS)
            begin
                cs_line_q     <= out_buf_q[1][PPS_B_CSBIT]; // [RL14]
                master_addr_q <= {1'b0, out_buf_q[1][5:0], out_buf_q[0]}; // [RL15]
            end
            else
            begin
                cs_line_q     <= 1'b0;
                master_addr_q <= {out_buf_q[1][6:0], out_buf_q[0]}; // [RL14]
            end
            port_addr_q <= out_buf_q[0];
            port_addr_oe_q[7:2] <= pen_low_q[7:2] & {6{is_master}}; // [RL2]
            port_addr_oe_q[1:0] <= pen_low_q[1:0] & {2{is_master}}; // [RL3]
        end
    end

    // Register read mux
    always_comb
    begin
        rd_mux = 8'h00;
        if (reg_addr == PPS_A_OSTAT)
            rd_mux = {all_empty, uf_q, 2'b00, empty_q};
        else if (reg_addr == PPS_A_ISTAT)
            rd_mux = {all_full, ov_q, 2'b00, full_q};
        else if (reg_addr == PPS_A_PENL)
            rd_mux = pen_low_q;
        else if (reg_addr == PPS_A_PENH)
            rd_mux = {1'b0, cs_pen_q, 6'h00};
        else if (reg_addr == PPS_A_CTRL)
            rd_mux = ctrl_q;
        else if (din_a[2])
            rd_mux = in_buf_q[din_a[1:0]];
        else if (reg_addr == PPS_A_ADRH && is_master)
            rd_mux = {1'b0, out_buf_q[1][6:0]}; // [RL15]
        else if (dout_a[2])
            rd_mux = out_buf_q[dout_a[1:0]];
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_q <= PPS_RST_BYTE;
        else if (reg_rd)
            reg_rdata_q <= rd_mux;
        else
            reg_rdata_q <= PPS_RST_BYTE;
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    AST_CS_PIN: assert property (cs_pen_q && is_master |=> cs_line_oe_q) // [RL1]
        else $error("cs pin not handed to port");
    AST_ADDR_PIN: assert property (!is_master |=> port_addr_oe_q[7:2] == 6'h00) // [RL2]
        else $error("address pin driven in slave mode");
    AST_STROBE_PIN: assert property (is_master && pen_low_q[1:0] == 2'b11 && $stable(pen_low_q) // [RL3]
        |=> port_addr_oe_q[1:0] == 2'b11)
        else $error("low address pins not enabled");
    AST_ALL_FULL: assert property (reg_rd && reg_addr == PPS_A_ISTAT && full_q == 4'hF // [RL4]
        |=> reg_rdata_q[7])
        else $error("all-full not shown");
    AST_OVERFLOW: assert property (ov_set ##1 // [RL5]
        !(reg_wr && reg_addr == PPS_A_ISTAT && !reg_wdata[PPS_B_STICKY]) |-> ov_q [*2])
        else $error("overflow not held");
    AST_FULL_CLR: assert property (reg_rd && reg_addr == PPS_A_DIN1L |=> !full_q[0]) // [RL6]
        else $error("full bit not cleared by read");
    AST_UNDERFLOW: assert property (uf_set |=> uf_q) // [RL8]
        else $error("underflow not set");
    AST_EMPTY_CLR: assert property (reg_wr && reg_addr == PPS_A_DOUT2L && !is_master // [RL9]
        && !(rd_start && rslot == 2'h2) |=> !empty_q[2])
        else $error("empty bit not cleared by write");
    AST_ADRH_B7: assert property (reg_rd && reg_addr == PPS_A_ADRH && is_master // [RL15]
        |=> reg_rdata_q[7] == 1'b0)
        else $error("address high bit 7 not zero");
    AST_PTR_STEP: assert property (wr_end && buffered |=> in_ptr_q == $past(in_ptr_q) + 2'h1) // [RL16]
        else $error("input pointer did not step");
    AST_W1_NOP: assert property (ov_q && reg_wr && reg_addr == PPS_A_ISTAT // [RL18]
        && reg_wdata[PPS_B_STICKY] |=> ov_q)
        else $error("writing one cleared overflow");

    COV_OVERFLOW: cover property (ov_set);
    COV_UNDERFLOW: cover property (uf_set);
    COV_FIFO_FULL: cover property (!fifo_rdy);
    COV_BUF_WRAP: cover property (buffered && wr_end && in_ptr_q == 2'h3);
endmodule // pps_core

// *** testbench/pps_ext_master.sv ***
// External bus master model driving the slave pins
// Assumes: clk_sys from the bench; pins sampled by the design's synchronisers
`timescale 1ns/1ps
module pps_ext_master
    import pps_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] data_out_q,
    input  wire logic       data_oe_q,
    output pps_pin_in_s     pin_o
);
    initial
    begin
        pin_o = '0;
    end

    // Strobes held 4 clocks, then released data shows inverse
    task automatic ext_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        pin_o <= '{1'b1, 1'b1, 1'b0, a, d};
        repeat (4) @(posedge clk_sys);
        pin_o.cs   <= 1'b0;
        pin_o.wr   <= 1'b0;
        pin_o.data <= ~d;
        repeat (10) @(posedge clk_sys);
    endtask

    // Read strobe held until the byte has settled
    task automatic ext_read(input logic [1:0] a, output logic [7:0] d, output logic oe);
        @(posedge clk_sys);
        pin_o <= '{1'b1, 1'b0, 1'b1, a, pin_o.data};
        repeat (6) @(posedge clk_sys);
        d  = data_out_q;
        oe = data_oe_q;
        pin_o.cs <= 1'b0;
        pin_o.rd <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask
endmodule // pps_ext_master

// *** testbench/pps_core_tb_top.sv ***
// Self-checking bench for the parallel port slave core
// Assumes: pps_pkg, design files and pps_ext_master compiled first
`timescale 1ns/1ps
module pps_core_tb_top
    import pps_pkg::*;
;
    logic        clk_sys;
    logic        sys_rst;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata_q;
    pps_pin_in_s pin_i;
    logic [7:0]  data_out_q;
    logic        data_oe_q;
    logic        cs_line_q;
    logic        cs_line_oe_q;
    logic [7:0]  port_addr_q;
    logic [7:0]  port_addr_oe_q;
    logic [14:0] master_addr_q;
    int          fails;
    int          checked;
    int          cycles = 0;

    pps_core pps_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .pin_i(pin_i), .data_out_q(data_out_q), .data_oe_q(data_oe_q), .cs_line_q(cs_line_q),
        .cs_line_oe_q(cs_line_oe_q), .port_addr_q(port_addr_q),
        .port_addr_oe_q(port_addr_oe_q), .master_addr_q(master_addr_q));
    pps_ext_master pps_ext_master_inst (.clk_sys(clk_sys), .data_out_q(data_out_q),
        .data_oe_q(data_oe_q), .pin_o(pin_i));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [14:0] seen, input logic [14:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic rw(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(name, reg_rdata_q, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_reset();
        rchk("ostat", PPS_A_OSTAT, 8'h8F);
        rchk("istat", PPS_A_ISTAT, 8'h00);
        rchk("penh", PPS_A_PENH, 8'h00);
        rchk("unmapped", 12'h123, 8'h00);
    endtask

    task automatic t_pins();
        rw(PPS_A_PENL, 8'hA5);
        rw(PPS_A_PENH, 8'hFF);
        rw(PPS_A_CTRL, 8'h03);
        settle();
        chk("addr_oe", port_addr_oe_q, 8'hA5);
        chk("cs_oe", cs_line_oe_q, 1'b1);
        rchk("penh", PPS_A_PENH, 8'h40);
        rchk("penl", PPS_A_PENL, 8'hA5);
        rw(PPS_A_PENL, 8'h00);
        rw(PPS_A_PENH, 8'h00);
        settle();
        chk("addr_oe", port_addr_oe_q, 8'h00);
        chk("cs_oe", cs_line_oe_q, 1'b0);
    endtask

    task automatic t_addr();
        rw(PPS_A_CTRL, 8'h83);
        rw(PPS_A_ADRH, 8'hFF);
        rw(PPS_A_ADRL, 8'h5A);
        settle();
        chk("cs", cs_line_q, 1'b1);
        chk("maddr", master_addr_q, 15'h3F5A);
        chk("paddr", port_addr_q, 8'h5A);
        rchk("adrh", PPS_A_ADRH, 8'h7F);
        rw(PPS_A_ADRH, 8'h3F);
        settle();
        chk("cs", cs_line_q, 1'b0);
        rw(PPS_A_CTRL, 8'hC2);
        rw(PPS_A_ADRH, 8'h40);
        settle();
        chk("maddr", master_addr_q, 15'h405A);
        chk("cs", cs_line_q, 1'b0);
    endtask

    task automatic t_inbuf();
        logic [7:0] d [4];
        d = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
        rw(PPS_A_CTRL, 8'h18);
        for (int i = 0; i < 3; i++)
            pps_ext_master_inst.ext_write(2'd0, d[i]);
        rchk("istat", PPS_A_ISTAT, 8'h07);
        pps_ext_master_inst.ext_write(2'd0, d[3]);
        rchk("istat", PPS_A_ISTAT, 8'h8F);
        pps_ext_master_inst.ext_write(2'd0, 8'hEE);
        rchk("istat", PPS_A_ISTAT, 8'hCF);
        for (int i = 0; i < 4; i++)
            rchk("din", PPS_A_DIN1L + 12'(i), d[i]);
        rchk("istat", PPS_A_ISTAT, 8'h40);
        rw(PPS_A_ISTAT, 8'hFF);
        rchk("istat", PPS_A_ISTAT, 8'h40);
        rw(PPS_A_ISTAT, 8'h00);
        rchk("istat", PPS_A_ISTAT, 8'h00);
    endtask

    task automatic t_outbuf();
        logic [11:0] a [4];
        logic [7:0]  d;
        logic        oe;
        a = '{PPS_A_ADRL, PPS_A_ADRH, PPS_A_DOUT2L, PPS_A_DOUT2H};
        rw(a[0], 8'h11);
        rchk("ostat", PPS_A_OSTAT, 8'h0E);
        for (int i = 1; i < 4; i++)
            rw(a[i], 8'h11 * 8'(i + 1));
        rchk("ostat", PPS_A_OSTAT, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            pps_ext_master_inst.ext_read(2'd0, d, oe);
            chk("dout", d, 8'h11 * 8'(i + 1));
            chk("data_oe", oe, 1'b1);
        end
        settle();
        chk("data_oe", data_oe_q, 1'b0);
        rchk("ostat", PPS_A_OSTAT, 8'h8F);
        pps_ext_master_inst.ext_read(2'd0, d, oe);
        rchk("ostat", PPS_A_OSTAT, 8'hCF);
        rw(PPS_A_OSTAT, 8'hFF);
        rchk("ostat", PPS_A_OSTAT, 8'hCF);
        rw(PPS_A_OSTAT, 8'h00);
        rchk("ostat", PPS_A_OSTAT, 8'h8F);
    endtask

    task automatic t_addressed();
        rw(PPS_A_CTRL, 8'h01);
        pps_ext_master_inst.ext_write(2'd2, 8'h5C);
        pps_ext_master_inst.ext_write(2'd0, 8'h6D);
        rchk("istat", PPS_A_ISTAT, 8'h05);
        rchk("din2l", PPS_A_DIN2L, 8'h5C);
        rchk("din1l", PPS_A_DIN1L, 8'h6D);
        rchk("istat", PPS_A_ISTAT, 8'h00);
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        fails     = 0;
        checked   = 0;
        sys_rst   = 1'b1;
        reg_addr  = 12'h000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_pins();
        t_addr();
        t_inbuf();
        t_outbuf();
        t_addressed();
        stop_test();
    end
endmodule // pps_core_tb_top
